// ===== hw/twdt_pkg.sv
// Package with register map, field layout and reset values of the watchdog
package twdt_pkg;

   // Bus geometry
   localparam int unsigned ADDR_WIDTH = 8;
   localparam int unsigned DATA_WIDTH = 32;

   // Register byte offsets
   localparam logic [7:0] OFFS_RELOAD   = 8'h00;
   localparam logic [7:0] OFFS_VALUE    = 8'h04;
   localparam logic [7:0] OFFS_CONTROL  = 8'h08;
   localparam logic [7:0] OFFS_INTCLEAR = 8'h0C;
   localparam logic [7:0] OFFS_RAWSTAT  = 8'h10;
   localparam logic [7:0] OFFS_MASKSTAT = 8'h14;
   localparam logic [7:0] OFFS_LOCK     = 8'h18;

   // Control register field positions
   localparam int unsigned CTRL_COUNT_EN_BIT = 0;
   localparam int unsigned CTRL_INT_EN_BIT   = 1;
   localparam int unsigned CTRL_RESET_EN_BIT = 2;
   localparam int unsigned CTRL_STALL_EN_BIT = 3;

   // Status and lock field positions
   localparam int unsigned STAT_INT_BIT    = 0;
   localparam int unsigned LOCK_STATE_BIT  = 0;

   // Unlock key, value is arbitrary
   localparam logic [31:0] UNLOCK_KEY = 32'h5A5A_0001;

   // Reset values
   localparam logic [31:0] RELOAD_RESET = 32'hFFFF_FFFF;
   localparam logic [31:0] COUNT_RESET  = 32'hFFFF_FFFF;
   localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;

   // AXI response codes
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Configuration held behind the lock
   typedef struct packed {
      logic stall_en;
      logic reset_en;
      logic int_en;
      logic count_en;
   } twdt_ctrl_type;

   localparam twdt_ctrl_type CTRL_RESET = '{
      stall_en: 1'b0,
      reset_en: 1'b0,
      int_en:   1'b0,
      count_en: 1'b0
   };

   // Write request as latched from the bus
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] data;
      logic [3:0]  strb;
   } twdt_write_type;

endpackage : twdt_pkg

// ===== hw/twdt_counter.sv
// Watchdog down counter with reload and zero detection
module twdt_counter (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // Control
   input  wire logic        run,
   input  wire logic        load,
   input  wire logic [31:0] load_value,
   // Status
   output logic      [31:0] count,
   output logic             zero_hit
);

   // A forced load takes the counter, yet a zero in that cycle still counts
   assign zero_hit = run && (count == twdt_pkg::ZERO_WORD);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count <= twdt_pkg::COUNT_RESET;
      end else if (load) begin
         count <= load_value;
      end else if (zero_hit) begin
         count <= load_value;
      end else if (run) begin
         count <= count - 32'h0000_0001;
      end
   end

endmodule : twdt_counter

// ===== hw/twdt_top.sv
// Two-stage watchdog timer with AXI4-Lite register slave
//
// Our own choices: the AXI4-Lite register port and the address map.
module twdt_top (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write address
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic [2:0]  s_axi_awprot,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic [2:0]  s_axi_arprot,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Debug state of the core
   input  wire logic        dbg_halt,
   // Watchdog outputs
   output logic             wdt_irq,
   output logic             wdt_sys_reset
);

   // Register state
   twdt_pkg::twdt_ctrl_type   ctrl;
   logic [31:0]               reload_value;
   logic                      locked;
   logic                      int_pending;
   logic                      sys_reset;

   // Write channel capture
   logic                      aw_held;
   logic                      w_held;
   logic [7:0]                aw_addr;
   logic [31:0]               w_data;
   logic [3:0]                w_strb;
   twdt_pkg::twdt_write_type  wr;
   logic                      wr_fire;

   // Decoded write strobes
   logic                      wr_reload;
   logic                      wr_control;
   logic                      wr_intclear;
   logic                      wr_lock;
   logic                      wr_mapped;
   logic                      wr_any_byte;
   logic [31:0]               next_reload_value;

   // Counter interface
   logic [31:0]               count;
   logic                      zero_hit;
   logic                      run;
   logic                      stalled;
   logic                      cnt_load;
   logic                      enable_edge;

   // Read side
   logic                      masked_status_select;
   logic                      masked_int;
   logic [31:0]               next_rdata;
   logic                      next_rd_ok;

   // Protection bits carry no meaning for this block
   logic                      prot_unused;
   assign prot_unused = ^{s_axi_awprot, s_axi_arprot};

   //------------------------------------------------------------------
   // Write address and data, accepted in either order
   //------------------------------------------------------------------
   assign s_axi_awready = !aw_held;
   assign s_axi_wready  = !w_held;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held <= 1'b0;
      end
   end

   // Both halves held and no response still owed
   assign wr_fire = aw_held && w_held && !s_axi_bvalid;

   assign wr.addr = {aw_addr[7:2], 2'h0};
   assign wr.data = w_data;
   assign wr.strb = w_strb;

   assign wr_any_byte = |wr.strb;
   assign wr_reload   = wr_fire && (wr.addr == twdt_pkg::OFFS_RELOAD);
   assign wr_control  = wr_fire && (wr.addr == twdt_pkg::OFFS_CONTROL);
   assign wr_intclear = wr_fire && (wr.addr == twdt_pkg::OFFS_INTCLEAR);
   assign wr_lock     = wr_fire && (wr.addr == twdt_pkg::OFFS_LOCK);

   // Read-only registers accept a write silently
   always_comb begin
      case (wr.addr)
         twdt_pkg::OFFS_RELOAD,
         twdt_pkg::OFFS_VALUE,
         twdt_pkg::OFFS_CONTROL,
         twdt_pkg::OFFS_INTCLEAR,
         twdt_pkg::OFFS_RAWSTAT,
         twdt_pkg::OFFS_MASKSTAT,
         twdt_pkg::OFFS_LOCK: wr_mapped = 1'b1;
         default:             wr_mapped = 1'b0;
      endcase
   end

   // Write response one cycle after both halves are in
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= twdt_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_mapped ? twdt_pkg::RESP_OKAY
                                   : twdt_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   //------------------------------------------------------------------
   // Lock
   //------------------------------------------------------------------
   // Key unlocks, any other value locks
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         locked <= 1'b0;
      end else if (wr_lock && wr_any_byte) begin
         if (wr.data == twdt_pkg::UNLOCK_KEY) begin
            locked <= 1'b0;
         end else begin
            locked <= 1'b1;
         end
      end
   end

   //------------------------------------------------------------------
   // Reload value
   //------------------------------------------------------------------
   genvar b;
   generate
      for (b = 0; b < 4; b++) begin : g_reload_lane
         assign next_reload_value[8*b +: 8] = wr.strb[b]
            ? wr.data[8*b +: 8] : reload_value[8*b +: 8];
      end
   endgenerate

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reload_value <= twdt_pkg::RELOAD_RESET;
      end else if (wr_reload && !locked) begin
         reload_value <= next_reload_value;
      end
   end

   //------------------------------------------------------------------
   // Control
   //------------------------------------------------------------------
   // Count and interrupt enables are set-only; a started watchdog halts only on reset or on dbg_halt with stall enabled
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= twdt_pkg::CTRL_RESET;
      end else if (wr_control && wr.strb[0] && !locked) begin
         if (wr.data[twdt_pkg::CTRL_COUNT_EN_BIT]) begin
            ctrl.count_en <= 1'b1;
            ctrl.int_en   <= 1'b1;
         end else if (wr.data[twdt_pkg::CTRL_INT_EN_BIT]) begin
            ctrl.int_en   <= 1'b1;
         end
         ctrl.reset_en <= wr.data[twdt_pkg::CTRL_RESET_EN_BIT];
         ctrl.stall_en <= wr.data[twdt_pkg::CTRL_STALL_EN_BIT];
      end
   end

   //------------------------------------------------------------------
   // Counter
   //------------------------------------------------------------------
   assign enable_edge = wr_control && wr.strb[0] && !locked && !ctrl.count_en
                        && wr.data[twdt_pkg::CTRL_COUNT_EN_BIT];

   // Debug halt is taken as synchronous to aclk, no filtering
   assign stalled = ctrl.stall_en && dbg_halt;
   assign run     = ctrl.count_en && !stalled;

   // Fresh reload value on enable, reload write or interrupt clear
   assign cnt_load = enable_edge
                  || (wr_reload && !locked)
                  || (wr_intclear && wr_any_byte);

   twdt_counter u_counter (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .run        (run),
      .load       (cnt_load),
      .load_value (cnt_load && wr_reload ? next_reload_value
                                         : reload_value),
      .count      (count),
      .zero_hit   (zero_hit)
   );

   //------------------------------------------------------------------
   // Interrupt and system reset
   //------------------------------------------------------------------
   // A timeout in the clearing cycle keeps the flag set
   // Clear ignores the lock so a handler can always drop the line
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         int_pending <= 1'b0;
      end else if (zero_hit) begin
         int_pending <= 1'b1;
      end else if (wr_reload && !locked
                   && next_reload_value == twdt_pkg::ZERO_WORD) begin
         int_pending <= 1'b1;
      end else if (wr_intclear && wr_any_byte) begin
         int_pending <= 1'b0;
      end
   end

   // Held until the system reset clears the whole block
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sys_reset <= 1'b0;
      end else if (zero_hit && int_pending && ctrl.reset_en) begin
         sys_reset <= 1'b1;
      end
   end

   assign masked_int    = int_pending && ctrl.int_en;
   assign wdt_irq       = masked_int;
   assign wdt_sys_reset = sys_reset;

   //------------------------------------------------------------------
   // Read channel
   //------------------------------------------------------------------
   // One read at a time; the address is decoded while it is offered
   assign s_axi_arready        = !s_axi_rvalid;
   assign masked_status_select = ({s_axi_araddr[7:2], 2'h0}
                                  == twdt_pkg::OFFS_MASKSTAT);

   always_comb begin
      next_rdata = 32'h0000_0000;
      next_rd_ok = 1'b1;
      case ({s_axi_araddr[7:2], 2'h0})
         twdt_pkg::OFFS_RELOAD: begin
            next_rdata = reload_value;
         end
         twdt_pkg::OFFS_VALUE: begin
            next_rdata = count;
         end
         twdt_pkg::OFFS_CONTROL: begin
            next_rdata[twdt_pkg::CTRL_COUNT_EN_BIT] = ctrl.count_en;
            next_rdata[twdt_pkg::CTRL_INT_EN_BIT]   = ctrl.int_en;
            next_rdata[twdt_pkg::CTRL_RESET_EN_BIT] = ctrl.reset_en;
            next_rdata[twdt_pkg::CTRL_STALL_EN_BIT] = ctrl.stall_en;
         end
         twdt_pkg::OFFS_INTCLEAR: begin
            next_rdata = 32'h0000_0000;
         end
         twdt_pkg::OFFS_RAWSTAT,
         twdt_pkg::OFFS_MASKSTAT: begin
            next_rdata[twdt_pkg::STAT_INT_BIT] =
               masked_status_select ? masked_int : int_pending;
         end
         twdt_pkg::OFFS_LOCK: begin
            next_rdata[twdt_pkg::LOCK_STATE_BIT] = locked;
         end
         default: begin
            next_rd_ok = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= twdt_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= next_rdata;
         s_axi_rresp  <= next_rd_ok ? twdt_pkg::RESP_OKAY
                                    : twdt_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Late clears by software: the handler should clear early

endmodule : twdt_top

// ===== tb/twdt_host.sv
// Software side of the watchdog: an AXI4-Lite master with bus tasks
module twdt_host (
   // Clock
   input  wire logic        aclk,
   // Write channels
   output logic      [7:0]  s_axi_awaddr,
   output logic      [2:0]  s_axi_awprot,
   output logic             s_axi_awvalid,
   input  wire logic        s_axi_awready,
   output logic      [31:0] s_axi_wdata,
   output logic      [3:0]  s_axi_wstrb,
   output logic             s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   output logic             s_axi_bready,
   // Read channels
   output logic      [7:0]  s_axi_araddr,
   output logic      [2:0]  s_axi_arprot,
   output logic             s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   output logic             s_axi_rready
);
   timeunit 1ns;
   timeprecision 1ns;
   // Extra cycles before taking a response
   int slow = 0;
   initial begin
      {s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata} = '0;
      {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arprot} = '0;
      {s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
   end
   // Handshakes are judged on the falling edge, where they are settled
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      logic ta, tw, ah, wh;
      {ah, wh} = 2'h0;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      do begin
         @(negedge aclk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         @(posedge aclk);
         // Released payload is scrambled so nothing reuses stale values
         if (ta) begin
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr  <= ~a;
         end
         if (tw) begin
            s_axi_wvalid <= 1'b0;
            s_axi_wdata  <= ~d;
         end
         ah |= ta;
         wh |= tw;
      end while (!(ah && wh));
      repeat (slow) @(posedge aclk);
      s_axi_bready <= 1'b1;
      do begin
         @(negedge aclk);
         ta = s_axi_bvalid;
         r  = s_axi_bresp;
         @(posedge aclk);
      end while (!ta);
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      logic t;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(negedge aclk);
         t = s_axi_arready;
         @(posedge aclk);
      end while (!t);
      s_axi_arvalid <= 1'b0;
      s_axi_araddr  <= ~a;
      repeat (slow) @(posedge aclk);
      s_axi_rready <= 1'b1;
      do begin
         @(negedge aclk);
         t = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
      end while (!t);
      s_axi_rready <= 1'b0;
   endtask : rd
endmodule : twdt_host

// ===== tb/twdt_props.sv
// Checker for the watchdog's bus handshakes and output pins
module twdt_props (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // Bus handshakes
   input  wire logic        s_axi_awready,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Watchdog outputs
   input  wire logic        wdt_irq,
   input  wire logic        wdt_sys_reset
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_idle_after_reset: assert property ($rose(aresetn) |->
      !wdt_irq && !wdt_sys_reset && !s_axi_bvalid && !s_axi_rvalid)
      else $error("outputs not idle after reset");
   a_reset_sticky: assert property (wdt_sys_reset |=> wdt_sys_reset)
      else $error("system reset dropped");
   a_reset_needs_irq: assert property ($rose(wdt_sys_reset) |->
      $past(wdt_irq)) else $error("system reset without pending irq");
   a_irq_by_clear: assert property ($fell(wdt_irq) |->
      $rose(s_axi_bvalid) && s_axi_bresp == twdt_pkg::RESP_OKAY)
      else $error("irq fell without a write");
   a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp not held");
   a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata not held");
   a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken during read data");
   a_write_fires: assert property ($rose(s_axi_bvalid) |->
      $past(s_axi_awready) == 1'b0 && $past(s_axi_wready) == 1'b0)
      else $error("write answered without both channels held");
endmodule : twdt_props

// ===== tb/testbench.sv
// Self-checking bench for the two-stage watchdog
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        aclk, aresetn, dbg_halt, wdt_irq, wdt_sys_reset;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [2:0]  s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   int          num_errors, check_count;
   twdt_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .dbg_halt, .wdt_irq, .wdt_sys_reset);
   twdt_host host (.aclk, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   // Whole run is some hundreds of cycles, far below this 20000-cycle limit
   initial begin
      repeat (20000) @(posedge aclk);
      num_errors++;
      close_out();
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : close_out
   task automatic chk(input string n, input logic [31:0] s, e);
      check_count++;
      if (s !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic w(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      host.wr(a, d, r);
      chk("bresp", {30'h0, r}, {30'h0, twdt_pkg::RESP_OKAY});
   endtask : w
   task automatic rdc(input string n, input logic [7:0] a,
                      input logic [31:0] e);
      logic [31:0] v;
      logic [1:0]  r;
      host.rd(a, v, r);
      chk(n, v, e);
   endtask : rdc
   task automatic vdiff(input string n, input logic [31:0] e);
      logic [31:0] a, b;
      logic [1:0]  r;
      host.rd(twdt_pkg::OFFS_VALUE, a, r);
      host.rd(twdt_pkg::OFFS_VALUE, b, r);
      chk(n, a - b, e);
   endtask : vdiff
   // Value must lie just below hi, a few cycles after a load
   task automatic vnear(input string n, input logic [31:0] hi);
      logic [31:0] v;
      logic [1:0]  r;
      host.rd(twdt_pkg::OFFS_VALUE, v, r);
      chk(n, {31'h0, v <= hi && v > hi - 32'hA}, 32'h1);
   endtask : vnear
   task automatic wait_hi(input bit rst, input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge aclk);
         if ((rst ? wdt_sys_reset : wdt_irq) === 1'b1) break;
      end
      @(posedge aclk);
   endtask : wait_hi
   task automatic do_reset();
      aresetn <= 1'b0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
   endtask : do_reset
   task automatic t_reset();
      rdc("reload", twdt_pkg::OFFS_RELOAD, twdt_pkg::RELOAD_RESET);
      rdc("value", twdt_pkg::OFFS_VALUE, twdt_pkg::COUNT_RESET);
      rdc("ctrl", twdt_pkg::OFFS_CONTROL, 32'h0);
      rdc("raw", twdt_pkg::OFFS_RAWSTAT, 32'h0);
      rdc("masked", twdt_pkg::OFFS_MASKSTAT, 32'h0);
      rdc("lock", twdt_pkg::OFFS_LOCK, 32'h0);
      vdiff("idle", 32'h0);
      $display("test reset done");
   endtask : t_reset
   task automatic t_unmapped();
      logic [31:0] v;
      logic [1:0]  r;
      host.wr(8'h1C, 32'h1, r);
      chk("bresp", {30'h0, r}, {30'h0, twdt_pkg::RESP_SLVERR});
      host.rd(8'h1C, v, r);
      chk("rresp", {30'h0, r}, {30'h0, twdt_pkg::RESP_SLVERR});
      chk("rdata", v, 32'h0);
      $display("test unmapped done");
   endtask : t_unmapped
   task automatic t_lock();
      w(twdt_pkg::OFFS_LOCK, 32'h0);
      rdc("locked", twdt_pkg::OFFS_LOCK, 32'h1);
      w(twdt_pkg::OFFS_CONTROL, 32'h7);
      rdc("ctrl", twdt_pkg::OFFS_CONTROL, 32'h0);
      vdiff("still", 32'h0);
      w(twdt_pkg::OFFS_RELOAD, 32'h64);
      rdc("reload", twdt_pkg::OFFS_RELOAD, twdt_pkg::RELOAD_RESET);
      w(twdt_pkg::OFFS_LOCK, twdt_pkg::UNLOCK_KEY);
      rdc("unlocked", twdt_pkg::OFFS_LOCK, 32'h0);
      $display("test lock done");
   endtask : t_lock
   task automatic t_timeout();
      w(twdt_pkg::OFFS_RELOAD, 32'h0);
      chk("irq", {31'h0, wdt_irq}, 32'h0);
      rdc("raw", twdt_pkg::OFFS_RAWSTAT, 32'h1);
      rdc("masked", twdt_pkg::OFFS_MASKSTAT, 32'h0);
      w(twdt_pkg::OFFS_CONTROL, 32'h2);
      rdc("ctrl", twdt_pkg::OFFS_CONTROL, 32'h2);
      chk("irq", {31'h0, wdt_irq}, 32'h1);
      w(twdt_pkg::OFFS_INTCLEAR, 32'h1);
      chk("irq", {31'h0, wdt_irq}, 32'h0);
      w(twdt_pkg::OFFS_RELOAD, 32'h64);
      w(twdt_pkg::OFFS_CONTROL, 32'h1);
      rdc("ctrl", twdt_pkg::OFFS_CONTROL, 32'h3);
      vdiff("count", 32'h2);
      wait_hi(1'b0, 200);
      chk("irq", {31'h0, wdt_irq}, 32'h1);
      rdc("raw", twdt_pkg::OFFS_RAWSTAT, 32'h1);
      rdc("masked", twdt_pkg::OFFS_MASKSTAT, 32'h1);
      vnear("reload", 32'h64);
      chk("sysrst", {31'h0, wdt_sys_reset}, 32'h0);
      w(twdt_pkg::OFFS_INTCLEAR, 32'h1);
      chk("irq", {31'h0, wdt_irq}, 32'h0);
      rdc("raw", twdt_pkg::OFFS_RAWSTAT, 32'h0);
      vnear("resume", 32'h64);
      $display("test timeout done");
   endtask : t_timeout
   task automatic t_reload();
      host.slow = 2;
      w(twdt_pkg::OFFS_RELOAD, 32'h1388);
      vnear("now", 32'h1388);
      rdc("reload", twdt_pkg::OFFS_RELOAD, 32'h1388);
      host.slow = 0;
      w(twdt_pkg::OFFS_RELOAD, 32'h0);
      chk("irq", {31'h0, wdt_irq}, 32'h1);
      w(twdt_pkg::OFFS_RELOAD, 32'hC8);
      w(twdt_pkg::OFFS_INTCLEAR, 32'h1);
      chk("irq", {31'h0, wdt_irq}, 32'h0);
      $display("test reload done");
   endtask : t_reload
   task automatic t_stall();
      w(twdt_pkg::OFFS_CONTROL, 32'h9);
      dbg_halt <= 1'b1;
      vdiff("halted", 32'h0);
      dbg_halt <= 1'b0;
      vdiff("running", 32'h2);
      w(twdt_pkg::OFFS_CONTROL, 32'h1);
      dbg_halt <= 1'b1;
      vdiff("nostall", 32'h2);
      dbg_halt <= 1'b0;
      $display("test stall done");
   endtask : t_stall
   task automatic t_second();
      w(twdt_pkg::OFFS_CONTROL, 32'h5);
      wait_hi(1'b0, 300);
      chk("irq", {31'h0, wdt_irq}, 32'h1);
      chk("sysrst", {31'h0, wdt_sys_reset}, 32'h0);
      wait_hi(1'b1, 300);
      chk("sysrst", {31'h0, wdt_sys_reset}, 32'h1);
      do_reset();
      chk("sysrst", {31'h0, wdt_sys_reset}, 32'h0);
      chk("irq", {31'h0, wdt_irq}, 32'h0);
      $display("test second done");
   endtask : t_second
   initial begin
      aresetn     = 1'b0;
      dbg_halt    = 1'b0;
      num_errors  = 0;
      check_count = 0;
      @(posedge aclk);
      do_reset();
      t_reset();
      t_unmapped();
      t_lock();
      t_timeout();
      t_reload();
      t_stall();
      t_second();
      close_out();
   end
endmodule : testbench

bind twdt_top twdt_props props (.aclk, .aresetn, .s_axi_awready,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
   .wdt_irq, .wdt_sys_reset);
